/* shared/tws_pkg.sv */
// Shared constants and types for the two-wire memory slave
package tws_pkg;
    // Clock rate and self-timed write duration
    localparam int CLK_HZ = 50_000_000;
    localparam int WRITE_TIME_MS = 5;
    localparam int WRITE_CYCLES = WRITE_TIME_MS * (CLK_HZ / 1000);
    localparam int TIMER_W = 18;
    // Array geometry
    localparam int ADDR_W = 15;
    localparam int PAGE_W = 6;
    localparam int MEM_WORDS = 32768;
    localparam int PAGE_BYTES = 64;
    // Framing
    localparam logic [3:0] CLASS_CODE = 4'ha;
    localparam logic [3:0] BITS_PER_WORD = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 15'h0000;
    // Byte roles within a transfer
    localparam logic [1:0] STG_DEV = 2'h0;
    localparam logic [1:0] STG_HI = 2'h1;
    localparam logic [1:0] STG_LO = 2'h2;
    localparam logic [1:0] STG_DATA = 2'h3;
    // Pins entering from outside the clock domain
    typedef struct packed {
        logic wp;
        logic [2:0] cs;
        logic scl;
        logic sda;
    } tws_pins_s;
    localparam tws_pins_s PINS_IDLE = 6'h03;
    // Protocol states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK,
        ST_WAIT
    } tws_state_e;
endpackage : tws_pkg

/* hdl/tws_sync.sv */
// Two-flop synchroniser for the pins of the two-wire slave
`timescale 1ns/1ps
module tws_sync
    import tws_pkg::*;
(
    // Clock, reset, enable
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic clk_en_in,
    // Pins
    input wire tws_pins_s async_in,
    output tws_pins_s sync_out
);
    tws_pins_s meta_r;
    tws_pins_s sync_r;

    generate
        for (genvar i = 0; i < $bits(tws_pins_s); i++) begin : g_bit
            always_ff @(posedge clock_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    meta_r[i] <= PINS_IDLE[i];
                    sync_r[i] <= PINS_IDLE[i];
                end else if (clk_en_in) begin
                    meta_r[i] <= async_in[i];
                    sync_r[i] <= meta_r[i];
                end
            end
        end
    endgenerate

    assign sync_out = sync_r;
endmodule : tws_sync

/* hdl/tws_slave.sv */
// Two-wire serial memory slave: protocol engine, address counter and array
`timescale 1ns/1ps
// Functional notes
// - Data changes only while clock low; changes with clock high are start or stop
// - Data falling with clock high is a start; one precedes every command
// - Data rising with clock high is a stop; after a read it gives standby
// - Words are eight bits; device pulls data low on ninth clock to acknowledge
// - Standby at power-up and after stop once internal work is done
// - Device address word starts with the fixed four-bit class pattern
// - Next three bits must match the three chip-select pins
// - Eighth address bit: one reads, zero writes
// - Match gives acknowledge; mismatch gives none and returns to standby
// - Write-protect pin high inhibits every array write
// - Byte write: device address, two address bytes, one data byte, stop
// - Stop after write starts 5 ms self-timed write; inputs ignored meanwhile
// - Page write takes up to 64 bytes, each acknowledged, ended by stop
// - Page write bumps only low six address bits, wrapping inside the page
// - Polling start plus address is acknowledged only after the write ends
// - Address counter holds last accessed address plus one across operations
// - Read address wraps from the last byte to the first byte
// - Current read: acknowledged read address, byte out, master nacks and stops
// - Sequential read continues while master acknowledges; nack plus stop ends it
// - Sample input on clock rise, change output on clock fall
// - 512 pages of 64 bytes; 15-bit address, top bit of high byte ignored
// - Write-protect low lets writes proceed; floating pin reads low
module tws_slave
    import tws_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES_P = WRITE_CYCLES
) (
    // Clock, reset, enable
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic clk_en_in,
    // Serial link
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // Straps and protection
    input wire logic wp_in,
    input wire logic chip_select_bit2_in,
    input wire logic chip_select_bit1_in,
    input wire logic chip_select_bit0_in,
    // Status
    output logic standby_out,
    output logic write_busy_out
);
    tws_pins_s pins_async;
    tws_pins_s pins;
    tws_state_e state_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic [1:0] stage_r;
    logic rw_r;
    logic macked_r;
    logic sda_oe_r;
    logic sda_lvl_r;
    logic scl_prev_r;
    logic sda_prev_r;
    logic [ADDR_W-1:0] addr_r;
    logic [PAGE_W-1:0] addr_off;
    logic [ADDR_W-PAGE_W-1:0] addr_page;
    logic [7:0] rd_q_r;
    logic [7:0] mem_r [MEM_WORDS];
    logic [7:0] pbuf_r [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] pvalid_r;
    logic busy_r;
    logic [TIMER_W-1:0] timer_r;
    logic [PAGE_W:0] copy_idx_r;
    logic standby_r;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic dev_match;
    logic rx_byte_end;
    logic rx_ack_end;
    logic tx_load;
    logic commit_go;
    logic copy_we;
    logic timer_end;

    assign pins_async = '{
        wp: wp_in,
        cs: {chip_select_bit2_in, chip_select_bit1_in, chip_select_bit0_in},
        scl: scl_in,
        sda: sda_in
    };

    tws_sync u_sync (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .clk_en_in(clk_en_in),
        .async_in(pins_async),
        .sync_out(pins)
    );

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end else if (clk_en_in) begin
            scl_prev_r <= pins.scl;
            sda_prev_r <= pins.sda;
        end
    end

    assign scl_rise = clk_en_in & pins.scl & ~scl_prev_r;
    assign scl_fall = clk_en_in & ~pins.scl & scl_prev_r;
    assign start_ev = clk_en_in & ~busy_r & pins.scl & scl_prev_r & sda_prev_r & ~pins.sda;
    assign stop_ev = clk_en_in & ~busy_r & pins.scl & scl_prev_r & ~sda_prev_r & pins.sda;

    assign dev_match = (shift_r[7:4] == CLASS_CODE) && (shift_r[3:1] == pins.cs);
    assign rx_byte_end = (state_r == ST_RX) && (bit_cnt_r == BITS_PER_WORD) && scl_fall;
    assign rx_ack_end = (state_r == ST_RX_ACK) && scl_fall;
    assign tx_load = (rx_ack_end && (stage_r == STG_DEV) && rw_r) ||
        ((state_r == ST_TX_ACK) && scl_fall && macked_r);
    assign commit_go = stop_ev && (|pvalid_r) && ~pins.wp;
    assign copy_we = busy_r && ~copy_idx_r[PAGE_W] && pvalid_r[copy_idx_r[PAGE_W-1:0]];
    assign timer_end = busy_r && (timer_r == '0);
    assign addr_off = addr_r[PAGE_W-1:0];
    assign addr_page = addr_r[ADDR_W-1:PAGE_W];

    // Protocol engine
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_r <= ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            stage_r <= STG_DEV;
            rw_r <= 1'b0;
            macked_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (stop_ev) begin
            state_r <= ST_IDLE;
            sda_oe_r <= 1'b0;
        end else if (start_ev) begin
            state_r <= ST_RX;
            bit_cnt_r <= 4'h0;
            stage_r <= STG_DEV;
            sda_oe_r <= 1'b0;
        end else if (tx_load) begin
            tx_r <= rd_q_r;
            sda_oe_r <= ~rd_q_r[7];
            bit_cnt_r <= 4'h1;
            state_r <= ST_TX;
        end else begin
            case (state_r)
                ST_RX: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], pins.sda};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (rx_byte_end) begin
                        if ((stage_r != STG_DEV) || dev_match) begin
                            sda_oe_r <= 1'b1;
                            state_r <= ST_RX_ACK;
                            if (stage_r == STG_DEV) begin
                                rw_r <= shift_r[0];
                            end
                        end else begin
                            state_r <= ST_WAIT;
                        end
                    end
                end
                ST_RX_ACK: begin
                    if (scl_fall) begin
                        sda_oe_r <= 1'b0;
                        state_r <= ST_RX;
                        bit_cnt_r <= 4'h0;
                        if (stage_r != STG_DATA) begin
                            stage_r <= stage_r + 2'h1;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_r == BITS_PER_WORD) begin
                            sda_oe_r <= 1'b0;
                            macked_r <= 1'b0;
                            state_r <= ST_TX_ACK;
                        end else begin
                            sda_oe_r <= ~tx_r[6];
                            tx_r <= {tx_r[6:0], 1'b0};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        macked_r <= ~pins.sda;
                    end else if (scl_fall) begin
                        state_r <= ST_WAIT;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Address counter
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            addr_r <= ADDR_RESET;
        end else if (tx_load) begin
            addr_r <= addr_r + ADDR_W'(1);
        end else if (rx_byte_end) begin
            if (stage_r == STG_HI) begin
                addr_r[ADDR_W-1:8] <= shift_r[ADDR_W-9:0];
            end else if (stage_r == STG_LO) begin
                addr_r[7:0] <= shift_r;
            end else if (stage_r == STG_DATA) begin
                addr_r[PAGE_W-1:0] <= addr_off + 6'h01;
            end
        end
    end

    // Page buffer data
    always_ff @(posedge clock_in) begin
        if (rx_byte_end && (stage_r == STG_DATA)) begin
            pbuf_r[addr_off] <= shift_r;
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pvalid_r <= '0;
        end else if (clk_en_in) begin
            if (start_ev || (stop_ev && !commit_go) || timer_end) begin
                pvalid_r <= '0;
            end else if (rx_byte_end && (stage_r == STG_DATA)) begin
                pvalid_r[addr_off] <= 1'b1;
            end
        end
    end

    // Array write and read port
    always_ff @(posedge clock_in) begin
        if (clk_en_in) begin
            if (copy_we) begin
                mem_r[{addr_page, copy_idx_r[PAGE_W-1:0]}] <= pbuf_r[copy_idx_r[PAGE_W-1:0]];
            end
            rd_q_r <= mem_r[addr_r];
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            busy_r <= 1'b0;
            timer_r <= '0;
            copy_idx_r <= '0;
        end else if (clk_en_in) begin
            if (commit_go) begin
                busy_r <= 1'b1;
                timer_r <= TIMER_W'(WRITE_CYCLES_P - 1);
                copy_idx_r <= '0;
            end else if (busy_r) begin
                if (!copy_idx_r[PAGE_W]) begin
                    copy_idx_r <= copy_idx_r + 7'h01;
                end
                if (timer_end) begin
                    busy_r <= 1'b0;
                end else begin
                    timer_r <= timer_r - TIMER_W'(1);
                end
            end
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            standby_r <= 1'b1;
            sda_lvl_r <= 1'b0;
        end else if (clk_en_in) begin
            // Standby when idle or waiting for the next start, and not writing
            standby_r <= ~busy_r & ((state_r == ST_IDLE) | (state_r == ST_WAIT));
            sda_lvl_r <= 1'b0;
        end
    end
    assign sda_out = sda_lvl_r;
    assign sda_oe_out = sda_oe_r;
    assign standby_out = standby_r;
    assign write_busy_out = busy_r;
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!resetn_in);
    property p_start_enters_rx;
        start_ev |=> (state_r == ST_RX) && (bit_cnt_r == 4'h0) && (stage_r == STG_DEV);
    endproperty
    a_start_enters_rx: assert property (p_start_enters_rx) else $error("start lost");
    property p_stop_standby;
        stop_ev && !commit_go |=> (state_r == ST_IDLE) && !sda_oe_r ##1 standby_r;
    endproperty
    a_stop_standby: assert property (p_stop_standby) else $error("no standby");
    property p_ack_on_match;
        rx_byte_end && (stage_r == STG_DEV) && dev_match |=> sda_oe_r && (state_r == ST_RX_ACK);
    endproperty
    a_ack_on_match: assert property (p_ack_on_match) else $error("address not acked");
    property p_nack_mismatch;
        rx_byte_end && (stage_r == STG_DEV) && !dev_match |=> !sda_oe_r && (state_r == ST_WAIT);
    endproperty
    a_nack_mismatch: assert property (p_nack_mismatch) else $error("mismatch acked");
    property p_wp_blocks;
        stop_ev && pins.wp |=> !busy_r;
    endproperty
    a_wp_blocks: assert property (p_wp_blocks) else $error("protected write started");
    property p_busy_min;
        $rose(busy_r) |-> busy_r [*8];
    endproperty
    a_busy_min: assert property (p_busy_min) else $error("write cycle too short");
    property p_poll_ignored;
        busy_r && (state_r == ST_IDLE) |=> (state_r == ST_IDLE) && !sda_oe_r;
    endproperty
    a_poll_ignored: assert property (p_poll_ignored) else $error("answered busy");
    property p_page_wrap;
        rx_byte_end && (stage_r == STG_DATA) |=> $stable(addr_page) &&
            (addr_off == $past(addr_off) + 6'h01);
    endproperty
    a_page_wrap: assert property (p_page_wrap) else $error("page address wrong");
    property p_read_inc;
        tx_load |=> addr_r == $past(addr_r) + ADDR_W'(1);
    endproperty
    a_read_inc: assert property (p_read_inc) else $error("read address not bumped");
    property p_drive_on_fall;
        $changed(sda_oe_r) |-> $past(scl_fall) || $past(stop_ev) || $past(start_ev);
    endproperty
    a_drive_on_fall: assert property (p_drive_on_fall) else $error("late drive");
    c_write_cycle: cover property ($rose(busy_r));
    c_read_byte: cover property (tx_load && (state_r == ST_TX_ACK));
    c_mismatch: cover property ((state_r == ST_RX) ##1 (state_r == ST_WAIT));
    c_page_end: cover property (rx_byte_end && (stage_r == STG_DATA) && (addr_off == 6'h3f));
endmodule : tws_slave

/* test/tws_master_model.sv */
// Bus master model that drives the two-wire link of the memory slave
`timescale 1ns/1ps
module tws_master_model (
    // Clock
    input wire logic clock_in,
    // Link: data open drain with pull-up, clock driven directly
    input wire logic sda_wire_in,
    output logic scl_out,
    output logic sda_drv_out,
    // Received words
    output logic rx_valid_out,
    output logic [7:0] rx_data_out
);
    initial begin
        scl_out = 1'b1;
        sda_drv_out = 1'b1;
        rx_valid_out = 1'b0;
        rx_data_out = 8'h00;
    end
    task quarter;
        repeat (2) @(negedge clock_in);
    endtask : quarter
    task report(input logic [7:0] v);
        rx_data_out = v;
        rx_valid_out = 1'b1;
        @(negedge clock_in);
        rx_valid_out = 1'b0;
    endtask : report
    task start;
        sda_drv_out = 1'b1;
        quarter();
        scl_out = 1'b1;
        quarter();
        sda_drv_out = 1'b0;
        quarter();
        scl_out = 1'b0;
        quarter();
    endtask : start
    task stop;
        sda_drv_out = 1'b0;
        quarter();
        scl_out = 1'b1;
        quarter();
        sda_drv_out = 1'b1;
        quarter();
        quarter();
    endtask : stop
    task bit_io(input logic b, output logic r);
        sda_drv_out = b;
        quarter();
        scl_out = 1'b1;
        quarter();
        r = sda_wire_in;
        quarter();
        scl_out = 1'b0;
        quarter();
    endtask : bit_io
    task recover;
        logic r;
        repeat (9) bit_io(1'b1, r);
    endtask : recover
    task write_byte(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        report({7'h00, r});
    endtask : write_byte
    task read_byte(input logic nack);
        logic [7:0] v;
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
        bit_io(nack, r);
        report(v);
    endtask : read_byte
endmodule : tws_master_model

/* test/tb_tws_slave.sv */
// Self-checking bench for the two-wire memory slave
`timescale 1ns/1ps
module tb_tws_slave;
    import tws_pkg::*;
    localparam int unsigned WC = 400;
    logic clock_in;
    logic resetn_in;
    logic clk_en;
    logic wp_in;
    logic [2:0] cs;
    logic scl;
    logic sda_drv;
    logic sda_wire;
    logic sda_out;
    logic sda_oe_out;
    logic standby_out;
    logic write_busy_out;
    logic rx_valid;
    logic [7:0] rx_data;
    logic [7:0] a;
    logic [7:0] exp_q[$];
    logic [7:0] d[0:4];
    int mismatches;
    int checked;
    int cycles;
    int busy_len;
    int seed;
    int frozen;
    assign sda_wire = sda_drv & (sda_oe_out ? sda_out : 1'b1);
    tws_slave #(.WRITE_CYCLES_P(WC)) i_tws_slave (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .clk_en_in(clk_en),
        .scl_in(scl),
        .sda_in(sda_wire),
        .sda_out(sda_out),
        .sda_oe_out(sda_oe_out),
        .wp_in(wp_in),
        .chip_select_bit2_in(cs[2]),
        .chip_select_bit1_in(cs[1]),
        .chip_select_bit0_in(cs[0]),
        .standby_out(standby_out),
        .write_busy_out(write_busy_out)
    );
    tws_master_model i_tws_master_model (
        .clock_in(clock_in),
        .sda_wire_in(sda_wire),
        .scl_out(scl),
        .sda_drv_out(sda_drv),
        .rx_valid_out(rx_valid),
        .rx_data_out(rx_data)
    );
    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task final_report;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report
    task wb(input logic [7:0] v, input logic [7:0] ack);
        exp_q.push_back(ack);
        i_tws_master_model.write_byte(v);
    endtask : wb
    task rb(input logic [7:0] e, input logic nack);
        exp_q.push_back(e);
        i_tws_master_model.read_byte(nack);
    endtask : rb
    task dev(input logic rw, input logic [7:0] ack);
        i_tws_master_model.start();
        wb({CLASS_CODE, cs, rw}, ack);
    endtask : dev
    task waddr(input logic [7:0] hi, input logic [7:0] lo);
        dev(1'b0, 8'h00);
        wb(hi, 8'h00);
        wb(lo, 8'h00);
    endtask : waddr
    task wait_idle;
        int n;
        n = 0;
        while (write_busy_out !== 1'b0 && n < 2000) begin
            @(negedge clock_in);
            n++;
        end
        repeat (4) @(negedge clock_in);
        check(32'(standby_out), 32'h1);
    endtask : wait_idle
    // Results from the master, oldest note first
    always @(posedge rx_valid) begin
        check(32'(rx_data), 32'(exp_q.pop_front()));
    end
    always @(negedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles > 20000) begin
            mismatches++;
            final_report();
        end
        if (write_busy_out === 1'b1) begin
            busy_len <= busy_len + 1;
        end else if (busy_len != 0) begin
            check(32'(busy_len), 32'(WC + frozen));
            busy_len <= 0;
        end
    end
    initial begin
        seed = 95;
        mismatches = 0;
        checked = 0;
        cycles = 0;
        busy_len = 0;
        frozen = 0;
        clk_en = 1'b1;
        resetn_in = 1'b0;
        wp_in = 1'b0;
        cs = 3'($random(seed));
        for (int i = 0; i < 5; i++) d[i] = 8'($random(seed));
        repeat (20) @(negedge clock_in);
        check(32'(standby_out), 32'h1);
        check(32'(sda_oe_out), 32'h0);
        resetn_in = 1'b1;
        repeat (4) @(negedge clock_in);
        i_tws_master_model.recover();
        for (int i = 0; i < 3; i++) begin
            a = {CLASS_CODE, cs, 1'b0};
            a = (i == 0) ? a ^ 8'h02 : (i == 1) ? a ^ 8'h09 : a ^ 8'h40;
            i_tws_master_model.start();
            wb(a, 8'h01);
            wb(d[i], 8'h01);
            i_tws_master_model.stop();
            check(32'(standby_out), 32'h1);
        end
        // Page write across the page end
        waddr(8'hff, 8'hfe);
        for (int i = 0; i < 4; i++) wb(d[i], 8'h00);
        i_tws_master_model.stop();
        check(32'(write_busy_out), 32'h1);
        dev(1'b0, 8'h01);
        i_tws_master_model.stop();
        wait_idle();
        dev(1'b0, 8'h00);
        i_tws_master_model.stop();
        waddr(8'h00, 8'h00);
        wb(d[4], 8'h00);
        i_tws_master_model.stop();
        // Clock enable low stretches the write cycle
        frozen = 10;
        clk_en = 1'b0;
        repeat (10) @(negedge clock_in);
        check(32'(write_busy_out), 32'h1);
        clk_en = 1'b1;
        wait_idle();
        // Protected write
        wp_in = 1'b1;
        waddr(8'h7f, 8'hc1);
        wb(~d[3], 8'h00);
        i_tws_master_model.stop();
        repeat (4) @(negedge clock_in);
        check(32'(write_busy_out), 32'h0);
        wp_in = 1'b0;
        // Random and sequential reads
        waddr(8'hff, 8'hfe);
        dev(1'b1, 8'h00);
        rb(d[0], 1'b0);
        rb(d[1], 1'b0);
        rb(d[4], 1'b1);
        i_tws_master_model.stop();
        check(32'(standby_out), 32'h1);
        waddr(8'h7f, 8'hc0);
        dev(1'b1, 8'h00);
        rb(d[2], 1'b1);
        i_tws_master_model.stop();
        dev(1'b1, 8'h00);
        rb(d[3], 1'b1);
        i_tws_master_model.stop();
        repeat (20) @(negedge clock_in);
        final_report();
    end
endmodule : tb_tws_slave
